//--- design/bdseq_top.sv
`timescale 1ns/1ps
module bdseq_top
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Operator controls.
    input wire logic restart,
    input wire logic [3:0] test_selector_switch,
    // Processor register access.
    input wire bdseq_pkg::bdseq_access_t cpu_acc,
    output logic [7:0] cpu_rdata,
    // Events from the plotter side.
    input wire bdseq_pkg::bdseq_event_t evt,
    input wire logic [7:0] irq_source,
    // Bus drive.
    output logic [15:0] bus_addr,
    output logic [7:0] bus_data,
    output logic bus_data_oe_n,
    output logic processor_go_disable_n,
    output logic data_drive_disable_n,
    output logic addr_strobe,
    output logic data_strobe,
    // Failing access loop and panel.
    output bdseq_pkg::bdseq_access_t loop_acc,
    output logic [7:0] parameter_entry_panel_led,
    output logic test_exit
);
    typedef struct packed
    {
        bdseq_pkg::bdseq_state_t st;
        logic [3:0] sel;
        logic [15:0] addr;
        logic [7:0] led;
        logic [7:0] irq_stat;
        logic [7:0] rdata;
        logic overrun;
        logic strobe;
        logic exit_flag;
        logic drive_n;
        logic [7:0] data;
        bdseq_pkg::bdseq_access_t loop;
    } bdseq_state_s_t;

    bdseq_state_s_t s_q;
    bdseq_state_s_t s_d;
    logic sg_strobe;
    logic sg_step;
    logic run;

    assign run = (s_q.st == bdseq_pkg::ST_STEP);

    bdseq_strobe_gen u_sg
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .run(run),
        .strobe(sg_strobe),
        .step(sg_step)
    );

    // ==========================================================
    // Register address decode.
    function automatic logic addr_hit(input bdseq_pkg::bdseq_access_t acc, input logic [15:0] a);
        return (acc.addr == a);
    endfunction

    // ==========================================================
    // Sequencer and panel registers.
    always_comb
    begin
        s_d = s_q;
        s_d.strobe = run ? sg_strobe : 1'b1;
        s_d.exit_flag = 1'b0;
        s_d.sel = test_selector_switch;
        s_d.irq_stat = s_q.irq_stat | irq_source;
        if (cpu_acc.wr && addr_hit(cpu_acc, bdseq_pkg::ADDR_LED))
        begin
            s_d.led = cpu_acc.data;
        end
        if (cpu_acc.rd)
        begin
            s_d.rdata = addr_hit(cpu_acc, bdseq_pkg::ADDR_IRQ_STATUS) ? s_q.irq_stat : 8'h00;
            if (addr_hit(cpu_acc, bdseq_pkg::ADDR_IRQ_STATUS))
            begin
                s_d.irq_stat = irq_source;
            end
        end
        if (evt.overrun)
        begin
            s_d.overrun = 1'b1;
        end
        else if (s_q.sel != test_selector_switch)
        begin
            s_d.overrun = 1'b0;
        end
        case (s_q.st)
            bdseq_pkg::ST_IDLE:
            begin
                if (restart && test_selector_switch == bdseq_pkg::SEL_ADDR_INC)
                begin
                    s_d.st = bdseq_pkg::ST_STEP;
                    s_d.addr = 16'h0000;
                end
            end
            bdseq_pkg::ST_STEP:
            begin
                if (restart || test_selector_switch != bdseq_pkg::SEL_ADDR_INC)
                begin
                    s_d.st = bdseq_pkg::ST_IDLE;
                end
                else if (sg_step)
                begin
                    s_d.addr = s_q.addr + 16'h0001;
                end
            end
            bdseq_pkg::ST_LOOP:
            begin
                if (restart)
                begin
                    s_d.st = bdseq_pkg::ST_IDLE;
                end
            end
            default:
            begin
                s_d.st = bdseq_pkg::ST_IDLE;
            end
        endcase
        if (s_q.st != bdseq_pkg::ST_STEP)
        begin
            if (evt.hs_fail && s_q.st == bdseq_pkg::ST_IDLE)
            begin
                s_d.st = bdseq_pkg::ST_LOOP;
                s_d.loop = cpu_acc;
                s_d.led = bdseq_pkg::CODE_HS_ERR;
            end
            else if (evt.irq_unexpected)
            begin
                s_d.led = bdseq_pkg::CODE_INT_ERR;
            end
            else if (s_d.overrun)
            begin
                s_d.led = bdseq_pkg::CODE_OVERRUN;
            end
            else if (evt.done)
            begin
                s_d.led = bdseq_pkg::CODE_DONE;
                s_d.exit_flag = 1'b1;
            end
        end
        s_d.drive_n = (s_d.st != bdseq_pkg::ST_STEP);
        s_d.data = bdseq_pkg::NOP_OPCODE;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.st <= bdseq_pkg::ST_IDLE;
            s_q.led <= bdseq_pkg::LED_RESET;
            s_q.strobe <= 1'b1;
            s_q.drive_n <= 1'b1;
            s_q.data <= bdseq_pkg::NOP_OPCODE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs straight from the state register.
    assign bus_addr = s_q.addr;
    assign bus_data = s_q.data;
    assign bus_data_oe_n = s_q.drive_n;
    assign processor_go_disable_n = s_q.drive_n;
    assign data_drive_disable_n = s_q.drive_n;
    assign addr_strobe = s_q.strobe;
    assign data_strobe = s_q.strobe;
    assign loop_acc = s_q.loop;
    assign parameter_entry_panel_led = s_q.led;
    assign test_exit = s_q.exit_flag;
    assign cpu_rdata = s_q.rdata;

    // ==========================================================
    // Checks.
    a_nop_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
        run |-> (bus_data == 8'h01 && !bus_data_oe_n)) else $error("nop not driven");
    a_disable_low: assert property (@(posedge ref_clk) disable iff (!rstn)
        run |-> (!processor_go_disable_n && !data_drive_disable_n)) else $error("disables high");
    a_addr_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        (run && sg_step && !restart && test_selector_switch == 4'h1)
        |=> bus_addr == $past(bus_addr) + 16'h0001)
        else $error("address not stepped");
    a_addr_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
        (run && sg_step && bus_addr == 16'hffff && !restart && test_selector_switch == 4'h1)
        |=> bus_addr == 16'h0000)
        else $error("address did not wrap");
    a_stop_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
        (run && restart) |=> !run) else $error("stepping not stopped");
    a_idle_strobe: assert property (@(posedge ref_clk) disable iff (!rstn)
        !run |=> (addr_strobe && data_strobe)) else $error("strobes not idle high");
    a_led_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cpu_acc.wr && cpu_acc.addr == 16'hffa3 && !evt.hs_fail && !evt.irq_unexpected && !evt.overrun
        && !s_q.overrun && !evt.done) |=> parameter_entry_panel_led == $past(cpu_acc.data))
        else $error("led write lost");
    a_status_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cpu_acc.rd && cpu_acc.addr == 16'hffa2) |=> cpu_rdata == $past(s_q.irq_stat))
        else $error("status read wrong");
    a_hs_code: assert property (@(posedge ref_clk) disable iff (!rstn)
        (evt.hs_fail && s_q.st == bdseq_pkg::ST_IDLE)
        |=> (parameter_entry_panel_led == 8'h77 && loop_acc == $past(cpu_acc)))
        else $error("handshake code missing");
    a_loop_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        (s_q.st == bdseq_pkg::ST_LOOP && !restart) |=> (s_q.st == bdseq_pkg::ST_LOOP && $stable(loop_acc)))
        else $error("failing access not held");
    a_irq_code: assert property (@(posedge ref_clk) disable iff (!rstn)
        (evt.irq_unexpected && !evt.hs_fail && s_q.st == bdseq_pkg::ST_IDLE) |=> parameter_entry_panel_led == 8'h99)
        else $error("interrupt code missing");
    a_overrun_code: assert property (@(posedge ref_clk) disable iff (!rstn)
        (evt.overrun && !evt.hs_fail && !evt.irq_unexpected && s_q.st == bdseq_pkg::ST_IDLE)
        |=> parameter_entry_panel_led == 8'haa) else $error("overrun code missing");
    a_done_exit: assert property (@(posedge ref_clk) disable iff (!rstn)
        test_exit |-> parameter_entry_panel_led == 8'h55) else $error("exit without done code");
endmodule

//--- design/bdseq_pkg.sv
package bdseq_pkg;

    // ==========================================================
    // Timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int ADDR_STEP_NS = 2000;
    localparam int STROBE_PERIOD_NS = 1000;
    localparam int ADDR_STEP_CYC = (ADDR_STEP_NS / CLK_PERIOD_NS);
    localparam int STROBE_HALF_CYC = (STROBE_PERIOD_NS / CLK_PERIOD_NS) / 2;

    // ==========================================================
    // Codes and addresses.
    localparam logic [7:0] NOP_OPCODE = 8'h01;
    localparam logic [7:0] CODE_INT_ERR = 8'h99;
    localparam logic [7:0] CODE_OVERRUN = 8'haa;
    localparam logic [7:0] CODE_HS_ERR = 8'h77;
    localparam logic [7:0] CODE_DONE = 8'h55;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hffa2;
    localparam logic [15:0] ADDR_LED = 16'hffa3;
    localparam logic [7:0] LED_RESET = 8'h00;
    localparam logic [3:0] SEL_ADDR_INC = 4'h1;

    // ==========================================================
    // Types.
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_STEP = 2'b01,
        ST_LOOP = 2'b10
    } bdseq_state_t;

    typedef struct packed
    {
        logic [15:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } bdseq_access_t;

    typedef struct packed
    {
        logic irq_unexpected;
        logic overrun;
        logic hs_fail;
        logic done;
    } bdseq_event_t;
endpackage

//--- design/bdseq_strobe_gen.sv
`timescale 1ns/1ps
module bdseq_strobe_gen
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Control.
    input wire logic run,
    // Timing outputs.
    output logic strobe,
    output logic step
);
    typedef struct packed
    {
        logic [7:0] cnt;
        logic strobe;
        logic step;
    } bdseq_sg_t;

    bdseq_sg_t s_q;
    bdseq_sg_t s_d;

    // ==========================================================
    // Strobe toggles each half period; step fires once per address period.
    always_comb
    begin
        s_d = s_q;
        s_d.step = 1'b0;
        if (!run)
        begin
            s_d.cnt = 8'h00;
            s_d.strobe = 1'b0;
        end
        else if (s_q.cnt == 8'(bdseq_pkg::ADDR_STEP_CYC - 1))
        begin
            s_d.cnt = 8'h00;
            s_d.strobe = 1'b0;
            s_d.step = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (((s_q.cnt + 8'h01) % 8'(bdseq_pkg::STROBE_HALF_CYC)) == 8'h00)
            begin
                s_d.strobe = ~s_q.strobe;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign strobe = s_q.strobe;
    assign step = s_q.step;

    a_step_period: assert property (@(posedge ref_clk) disable iff (!rstn)
        step |-> ##1 !step) else $error("step longer than one cycle");
endmodule

//--- dv/bdseq_plotter_model.sv
`timescale 1ns/1ps
module bdseq_plotter_model
(
    // Clock.
    input wire logic ref_clk,
    // Toward the sequencer.
    output bdseq_pkg::bdseq_access_t cpu_acc,
    output bdseq_pkg::bdseq_event_t evt,
    output logic [7:0] irq_source
);
    // ==========================================================
    // Processor side of the bus.
    initial
    begin
        cpu_acc = '0;
        evt = '0;
        irq_source = 8'h00;
    end

    // One access and one event word for one cycle; released address and data show inverted values, wr, rd and events clear.
    task automatic access(input logic wr, input logic rd, input logic [15:0] a, input logic [7:0] d,
                          input bdseq_pkg::bdseq_event_t e);
        @(posedge ref_clk);
        cpu_acc <= '{addr: a, data: d, wr: wr, rd: rd};
        evt <= e;
        @(posedge ref_clk);
        cpu_acc <= '{addr: ~a, data: ~d, wr: 1'b0, rd: 1'b0};
        evt <= '0;
    endtask

    // Changes the interrupt source lines at the next clock edge.
    task automatic set_irq(input logic [7:0] v);
        @(posedge ref_clk);
        irq_source <= v;
    endtask
endmodule

//--- dv/test_bus_diagnostic_sequencer.sv
`timescale 1ns/1ps
module test_bus_diagnostic_sequencer;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic restart = 1'b0;
    logic [3:0] test_selector_switch = 4'h0;
    bdseq_pkg::bdseq_access_t cpu_acc;
    bdseq_pkg::bdseq_access_t loop_acc;
    bdseq_pkg::bdseq_event_t evt;
    logic [7:0] irq_source;
    logic [7:0] cpu_rdata;
    logic [7:0] bus_data;
    logic [7:0] parameter_entry_panel_led;
    logic [15:0] bus_addr;
    logic bus_data_oe_n;
    logic processor_go_disable_n;
    logic data_drive_disable_n;
    logic addr_strobe;
    logic data_strobe;
    logic test_exit;
    logic exit_seen = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (test_exit === 1'b1) exit_seen <= 1'b1;

    // ==========================================================
    // Design and far side.
    bdseq_top dut (.ref_clk, .rstn, .restart, .test_selector_switch, .cpu_acc, .cpu_rdata, .evt, .irq_source,
        .bus_addr, .bus_data, .bus_data_oe_n, .processor_go_disable_n, .data_drive_disable_n, .addr_strobe,
        .data_strobe, .loop_acc, .parameter_entry_panel_led, .test_exit);
    bdseq_plotter_model m (.ref_clk, .cpu_acc, .evt, .irq_source);

    // ==========================================================
    // Helpers.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Counts cycles until the address (which 0) or the strobe (which 1) changes, at most 300.
    task automatic wait_change(input int which, output int n);
        logic [15:0] v;
        v = which ? {15'h0000, addr_strobe} : bus_addr;
        n = 0;
        while ((which ? {15'h0000, addr_strobe} : bus_addr) === v && n < 300)
        begin
            step(1);
            n++;
        end
    endtask

    task automatic pulse_restart();
        @(posedge ref_clk);
        restart <= 1'b1;
        @(posedge ref_clk);
        restart <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios.
    task automatic t_reg();
        #1;
        check(parameter_entry_panel_led, bdseq_pkg::LED_RESET);
        check({addr_strobe, data_strobe}, 2'b11);
        check({processor_go_disable_n, data_drive_disable_n}, 2'b11);
        m.access(1'b1, 1'b0, bdseq_pkg::ADDR_LED, 8'h5a, '0);
        #1;
        check(parameter_entry_panel_led, 8'h5a);
        m.access(1'b1, 1'b0, 16'h1000, 8'hff, '0);
        #1;
        check(parameter_entry_panel_led, 8'h5a);
        m.set_irq(8'h05);
        m.access(1'b0, 1'b1, bdseq_pkg::ADDR_IRQ_STATUS, 8'h00, '0);
        #1;
        check(cpu_rdata, 8'h05);
        m.access(1'b0, 1'b1, 16'h1000, 8'h00, '0);
        #1;
        check(cpu_rdata, 8'h00);
        m.set_irq(8'h00);
        m.access(1'b0, 1'b1, bdseq_pkg::ADDR_IRQ_STATUS, 8'h00, '0);
        #1;
        check(cpu_rdata, 8'h05);
        m.access(1'b0, 1'b1, bdseq_pkg::ADDR_IRQ_STATUS, 8'h00, '0);
        #1;
        check(cpu_rdata, 8'h00);
        $display("test registers finished");
    endtask

    task automatic t_step();
        int n;
        logic [15:0] a;
        @(posedge ref_clk);
        test_selector_switch <= bdseq_pkg::SEL_ADDR_INC;
        pulse_restart();
        step(2);
        check(bus_data, bdseq_pkg::NOP_OPCODE);
        check(bus_data_oe_n, 1'b0);
        check({processor_go_disable_n, data_drive_disable_n}, 2'b00);
        wait_change(0, n);
        a = bus_addr;
        wait_change(0, n);
        check(16'(n), 16'(bdseq_pkg::ADDR_STEP_CYC));
        check(bus_addr, a + 16'h0001);
        wait_change(1, n);
        wait_change(1, n);
        check(16'(n), 16'(bdseq_pkg::STROBE_HALF_CYC));
        check({addr_strobe, data_strobe}, 2'b00);
        wait_change(0, n);
        check(bus_addr, a + 16'h0002);
        @(posedge ref_clk);
        test_selector_switch <= 4'h2;
        step(2);
        check({processor_go_disable_n, data_drive_disable_n}, 2'b11);
        wait_change(0, n);
        check(16'(n), 16'h012c);
        @(posedge ref_clk);
        test_selector_switch <= bdseq_pkg::SEL_ADDR_INC;
        pulse_restart();
        step(2);
        check({processor_go_disable_n, data_drive_disable_n}, 2'b00);
        pulse_restart();
        step(2);
        check({processor_go_disable_n, data_drive_disable_n}, 2'b11);
        check({addr_strobe, data_strobe}, 2'b11);
        $display("test stepping finished");
    endtask

    task automatic t_codes();
        bdseq_pkg::bdseq_event_t ev [3] = '{4'b1000, 4'b0001, 4'b0100};
        logic [7:0] code [3] = '{bdseq_pkg::CODE_INT_ERR, bdseq_pkg::CODE_DONE, bdseq_pkg::CODE_OVERRUN};
        for (int i = 0; i < 3; i++)
        begin
            m.access(1'b0, 1'b0, 16'h0000, 8'h00, ev[i]);
            step(1);
            check(parameter_entry_panel_led, code[i]);
        end
        m.access(1'b0, 1'b0, 16'h0000, 8'h00, 4'b0001);
        step(1);
        check(parameter_entry_panel_led, bdseq_pkg::CODE_OVERRUN);
        check(exit_seen, 1'b1);
        @(posedge ref_clk);
        test_selector_switch <= 4'h3;
        m.access(1'b0, 1'b0, 16'h0000, 8'h00, 4'b0001);
        step(1);
        check(parameter_entry_panel_led, bdseq_pkg::CODE_DONE);
        m.access(1'b0, 1'b1, 16'h1234, 8'h00, 4'b0010);
        step(4);
        check(parameter_entry_panel_led, bdseq_pkg::CODE_HS_ERR);
        check(loop_acc.addr, 16'h1234);
        check(loop_acc.rd, 1'b1);
        pulse_restart();
        $display("test codes finished");
    endtask

    // ==========================================================
    // Sequence, watchdog and verdict.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reg();
        t_step();
        t_codes();
        print_verdict();
    end

    initial
    begin
        #(20 * 20000);
        n_errors++;
        print_verdict();
    end
endmodule
